/* File: rtl/indexer_defines.vh */
`ifndef INDEXER_DEFINES_VH
`define INDEXER_DEFINES_VH

// Register byte addresses
`define OFS_CTRL 8'h00
`define OFS_DIVISIONS 8'h04
`define OFS_PITCH 8'h08
`define OFS_REMOTE_SPEED 8'h0c
`define OFS_HOME_ADDR 8'h10
`define OFS_HOME_SHIFT 8'h14
`define OFS_JOG_SPEED 8'h18
`define OFS_HOME_SPEED 8'h1c
`define OFS_QUERY 8'h20
`define OFS_STATUS 8'h24
`define OFS_POSITION 8'h28
`define OFS_REPLY0 8'h2c
`define OFS_TABLE 8'h40
// Control fields
`define CTRL_MODE_LSB 0
`define CTRL_DIR_BIT 3
`define CTRL_TWO_STATION_BIT 4
`define CTRL_HOME_DIR_BIT 5
// Operation modes
`define MODE_DIR_INDEX 3'h0
`define MODE_SHORT_INDEX 3'h1
`define MODE_INDEX_JOG 3'h2
`define MODE_JOG 3'h3
`define MODE_DOG_HOME 3'h4
`define MODE_DATA_HOME 3'h5
`define MODE_RETURN_HOME 3'h6
// Reset values
`define RST_CTRL 32'h00000000
`define RST_DIVISIONS 8'h04
`define RST_PITCH 24'h000064
`define RST_SPEED 16'h0100
// Limits
`define MAX_STATION_ONE 8'h1f
`define MAX_STATION_TWO 9'h0ff
`define REV_OVERFLOW 15'h2000
// Master query codes
`define QRY_CMD_READ 8'h02
`define QRY_DATA_CMD_POS 8'h91
`define QRY_DATA_VERSION 8'h70
`define VERSION_CHARS 15
`define CHAR_SPACE 8'h20
`endif

/* File: rtl/indexer_station_positioning.v */
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`include "indexer_defines.vh"
module indexer_station_positioning #(
    parameter PULSES_PER_REV = 262144,
    parameter [119:0] VERSION_STRING = "A0.00.0 EXAMPLE"
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] next_station_select,
    input wire [2:0] speed_select,
    input wire motion_start_input,
    input wire proximity_dog,
    input wire zero_phase_pulse,
    output reg step_out,
    output reg dir_out,
    output reg busy,
    output reg in_position,
    output reg station_error,
    output reg home_done,
    output reg pos_overflow
);
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_RUN = 7'h02;
    localparam [6:0] ST_JOG = 7'h04;
    localparam [6:0] ST_JOG_STOP = 7'h08;
    localparam [6:0] ST_HOME_SEEK = 7'h10;
    localparam [6:0] ST_HOME_Z = 7'h20;
    localparam [6:0] ST_HOME_OFFS = 7'h40;
    localparam [17:0] REV_LAST = PULSES_PER_REV[17:0] - 18'h1;

    reg [31:0] ctrl_reg;
    reg [7:0] divisions_reg;
    reg [23:0] pitch_reg;
    reg [15:0] remote_speed_reg;
    reg [31:0] home_addr_reg;
    reg [31:0] home_shift_reg;
    reg [15:0] jog_speed_reg;
    reg [15:0] home_speed_reg;
    reg [15:0] query_reg;
    reg [127:0] reply_reg;
    reg reply_ok_reg;
    reg [31:0] table_reg [0:7];
    reg [7:0] aw_addr_reg;
    reg aw_held;
    reg [31:0] w_data_reg;
    reg w_held;

    reg [6:0] state_reg;
    reg [31:0] pos_reg;
    reg [31:0] target_reg;
    reg [23:0] sub_pitch_reg;
    reg [31:0] count_reg;
    reg [15:0] acc_reg;
    reg [15:0] speed_reg;
    reg [17:0] rev_pulse_reg;
    reg signed [14:0] rev_reg;
    reg start_d;
    reg z_d;

    wire [2:0] mode;
    wire two_station;
    wire [31:0] total;
    wire [31:0] station_pos;
    wire path_dir;
    wire at_target;
    wire [127:0] reply_chars;
    wire reply_ok;
    wire [16:0] acc_sum;
    wire step_en;
    wire start_rise;
    wire z_rise;
    wire station_bad;
    wire stop_here;
    wire move_dir;
    wire [31:0] pos_fwd;
    wire [31:0] pos_back;
    wire [15:0] table_speed;
    wire do_write;
    wire [7:0] wa;
    wire [7:0] ra;
    integer k;

    assign mode = ctrl_reg[`CTRL_MODE_LSB+2:`CTRL_MODE_LSB];
    assign two_station = ctrl_reg[`CTRL_TWO_STATION_BIT];
    assign total = {24'h000000, divisions_reg} * {8'h00, pitch_reg};
    // Station number is plain binary, bit0 as LSB
    assign station_pos = {24'h000000, next_station_select} * {8'h00, pitch_reg};
    assign station_bad = (next_station_select >= divisions_reg) ||
        (!two_station && next_station_select >= `MAX_STATION_ONE) ||
        (next_station_select > 8'hfe);
    assign table_speed = table_reg[speed_select][15:0];
    assign acc_sum = {1'b0, acc_reg} + {1'b0, speed_reg};
    assign step_en = acc_sum[16] && (state_reg != ST_IDLE);
    assign start_rise = motion_start_input && !start_d;
    assign z_rise = zero_phase_pulse && !z_d;
    // No step in the cycle an index, home-offset or index-jog stop completes
    assign stop_here = (state_reg == ST_RUN && at_target) || (count_reg == 32'h0 &&
        (state_reg == ST_HOME_OFFS || (state_reg == ST_JOG_STOP && sub_pitch_reg == 24'h0)));
    assign pos_fwd = (pos_reg + 32'h1 >= total) ? 32'h0 : pos_reg + 32'h1;
    assign pos_back = (pos_reg == 32'h0) ? total - 32'h1 : pos_reg - 32'h1;
    assign move_dir = (state_reg == ST_RUN) ? path_dir :
        (state_reg[6:4] != 3'h0) ? ctrl_reg[`CTRL_HOME_DIR_BIT] :
        ctrl_reg[`CTRL_DIR_BIT];
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wa = aw_addr_reg;
    assign ra = s_axi_araddr;

    station_path_select u_path (
        .pos(pos_reg),
        .target(target_reg),
        .total(total),
        .fixed_dir(ctrl_reg[`CTRL_DIR_BIT]),
        .shortest(mode == `MODE_SHORT_INDEX),
        .dir(path_dir),
        .at_target(at_target)
    );

    reply_formatter #(
        .VERSION_STRING(VERSION_STRING)
    ) u_reply (
        .query_cmd(query_reg[15:8]),
        .query_data(query_reg[7:0]),
        .position(pos_reg),
        .reply_chars(reply_chars),
        .reply_ok(reply_ok)
    );

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data_reg <= s_axi_wdata;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wa[1:0] != 2'h0 || (wa > `OFS_QUERY && wa < `OFS_TABLE) ||
                    wa > `OFS_TABLE + 8'h1c) ? 2'h2 : 2'h0;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register file, query latch
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `RST_CTRL;
            divisions_reg <= `RST_DIVISIONS;
            pitch_reg <= `RST_PITCH;
            remote_speed_reg <= `RST_SPEED;
            home_addr_reg <= 32'h00000000;
            home_shift_reg <= 32'h00000000;
            jog_speed_reg <= `RST_SPEED;
            home_speed_reg <= `RST_SPEED;
            query_reg <= 16'h0000;
            for (k = 0; k < 8; k = k + 1) begin
                table_reg[k] <= {16'h0000, `RST_SPEED};
            end
        end else if (do_write) begin
            case (wa)
                `OFS_CTRL: ctrl_reg <= w_data_reg;
                `OFS_DIVISIONS: divisions_reg <= w_data_reg[7:0];
                `OFS_PITCH: pitch_reg <= w_data_reg[23:0];
                `OFS_REMOTE_SPEED: remote_speed_reg <= w_data_reg[15:0];
                `OFS_HOME_ADDR: home_addr_reg <= w_data_reg;
                `OFS_HOME_SHIFT: home_shift_reg <= w_data_reg;
                `OFS_JOG_SPEED: jog_speed_reg <= w_data_reg[15:0];
                `OFS_HOME_SPEED: home_speed_reg <= w_data_reg[15:0];
                `OFS_QUERY: query_reg <= w_data_reg[15:0];
                default: begin
                    if (wa[7:5] == 3'h2 && wa[1:0] == 2'h0) begin
                        table_reg[wa[4:2]] <= w_data_reg;
                    end
                end
            endcase
        end
    end

    // Reply buffer catches the answer one cycle after the query is written
    always @(posedge aclk) begin
        if (!aresetn) begin
            reply_reg <= {16{`CHAR_SPACE}};
            reply_ok_reg <= 1'b0;
        end else begin
            reply_reg <= reply_chars;
            reply_ok_reg <= reply_ok;
        end
    end

    // Read channel: one-cycle answer
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (ra)
                    `OFS_CTRL: s_axi_rdata <= ctrl_reg;
                    `OFS_DIVISIONS: s_axi_rdata <= {24'h0, divisions_reg};
                    `OFS_PITCH: s_axi_rdata <= {8'h0, pitch_reg};
                    `OFS_REMOTE_SPEED: s_axi_rdata <= {16'h0, remote_speed_reg};
                    `OFS_HOME_ADDR: s_axi_rdata <= home_addr_reg;
                    `OFS_HOME_SHIFT: s_axi_rdata <= home_shift_reg;
                    `OFS_JOG_SPEED: s_axi_rdata <= {16'h0, jog_speed_reg};
                    `OFS_HOME_SPEED: s_axi_rdata <= {16'h0, home_speed_reg};
                    `OFS_QUERY: s_axi_rdata <= {16'h0, query_reg};
                    `OFS_STATUS: s_axi_rdata <= {19'h0, state_reg, reply_ok_reg,
                        pos_overflow, home_done, station_error, in_position, busy};
                    `OFS_POSITION: s_axi_rdata <= pos_reg;
                    `OFS_REPLY0: s_axi_rdata <= reply_reg[127:96];
                    `OFS_REPLY0 + 8'h04: s_axi_rdata <= reply_reg[95:64];
                    `OFS_REPLY0 + 8'h08: s_axi_rdata <= reply_reg[63:32];
                    `OFS_REPLY0 + 8'h0c: s_axi_rdata <= reply_reg[31:0];
                    default: begin
                        if (ra[7:5] == 3'h2 && ra[1:0] == 2'h0) begin
                            s_axi_rdata <= table_reg[ra[4:2]];
                        end else begin
                            s_axi_rdata <= 32'h00000000;
                            s_axi_rresp <= 2'h2;
                        end
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Motion sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            pos_reg <= 32'h00000000;
            target_reg <= 32'h00000000;
            sub_pitch_reg <= 24'h000000;
            count_reg <= 32'h00000000;
            acc_reg <= 16'h0000;
            speed_reg <= 16'h0000;
            start_d <= 1'b0;
            z_d <= 1'b0;
            step_out <= 1'b0;
            dir_out <= 1'b0;
            busy <= 1'b0;
            in_position <= 1'b0;
            station_error <= 1'b0;
            home_done <= 1'b0;
        end else begin
            start_d <= motion_start_input;
            z_d <= zero_phase_pulse;
            acc_reg <= (state_reg == ST_IDLE) ? 16'h0000 : acc_sum[15:0];
            step_out <= 1'b0;
            busy <= (state_reg != ST_IDLE);
            if (step_en) begin
                step_out <= !stop_here;
                dir_out <= move_dir;
            end
            if (step_en && !stop_here) begin
                pos_reg <= move_dir ? pos_fwd : pos_back;
                if (move_dir) begin
                    sub_pitch_reg <= (sub_pitch_reg + 24'h1 >= pitch_reg) ? 24'h0 :
                        sub_pitch_reg + 24'h1;
                end else begin
                    sub_pitch_reg <= (sub_pitch_reg == 24'h0) ? pitch_reg - 24'h1 :
                        sub_pitch_reg - 24'h1;
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    if (start_rise) begin
                        in_position <= 1'b0;
                        station_error <= 1'b0;
                        speed_reg <= two_station ? remote_speed_reg : table_speed;
                        case (mode)
                            `MODE_DIR_INDEX, `MODE_SHORT_INDEX: begin
                                if (station_bad) begin
                                    station_error <= 1'b1;
                                end else begin
                                    target_reg <= station_pos;
                                    state_reg <= ST_RUN;
                                end
                            end
                            `MODE_INDEX_JOG: state_reg <= ST_JOG;
                            `MODE_JOG: begin
                                speed_reg <= jog_speed_reg;
                                state_reg <= ST_JOG;
                            end
                            `MODE_DOG_HOME: begin
                                speed_reg <= home_speed_reg;
                                home_done <= 1'b0;
                                state_reg <= ST_HOME_SEEK;
                            end
                            `MODE_DATA_HOME: begin
                                pos_reg <= home_addr_reg;
                                sub_pitch_reg <= 24'h0;
                                home_done <= 1'b1;
                                in_position <= 1'b1;
                            end
                            `MODE_RETURN_HOME: begin
                                if (!home_done) begin
                                    station_error <= 1'b1;
                                end else begin
                                    target_reg <= home_addr_reg;
                                    speed_reg <= home_speed_reg;
                                    state_reg <= ST_RUN;
                                end
                            end
                            default: station_error <= 1'b1;
                        endcase
                    end
                end
                ST_RUN: begin
                    if (at_target) begin
                        in_position <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_JOG: begin
                    if (!motion_start_input) begin
                        if (mode == `MODE_INDEX_JOG) begin
                            // Deceleration distance from the selected table entry
                            count_reg <= {16'h0, table_reg[speed_select][31:16]};
                            state_reg <= ST_JOG_STOP;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_JOG_STOP: begin
                    if (count_reg == 32'h0 && sub_pitch_reg == 24'h0) begin
                        in_position <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else if (step_en && count_reg != 32'h0) begin
                        count_reg <= count_reg - 32'h1;
                    end
                end
                ST_HOME_SEEK: begin
                    if (proximity_dog) begin
                        count_reg <= home_shift_reg;
                        state_reg <= ST_HOME_Z;
                    end
                end
                ST_HOME_Z: begin
                    if (z_rise) begin
                        count_reg <= home_shift_reg;
                        state_reg <= ST_HOME_OFFS;
                    end
                end
                ST_HOME_OFFS: begin
                    if (count_reg == 32'h0) begin
                        pos_reg <= home_addr_reg;
                        sub_pitch_reg <= 24'h0;
                        home_done <= 1'b1;
                        in_position <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else if (step_en) begin
                        count_reg <= count_reg - 32'h1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Motor-side revolution count from home
    always @(posedge aclk) begin
        if (!aresetn) begin
            rev_pulse_reg <= 18'h0;
            rev_reg <= 15'h0;
            pos_overflow <= 1'b0;
        end else if ((state_reg == ST_IDLE && start_rise && mode == `MODE_DATA_HOME) ||
            (state_reg == ST_HOME_OFFS && count_reg == 32'h0)) begin
            rev_pulse_reg <= 18'h0;
            rev_reg <= 15'h0;
            pos_overflow <= 1'b0;
        end else if (step_en && !stop_here) begin
            if (move_dir) begin
                if (rev_pulse_reg == REV_LAST) begin
                    rev_pulse_reg <= 18'h0;
                    rev_reg <= rev_reg + 15'sh1;
                end else begin
                    rev_pulse_reg <= rev_pulse_reg + 18'h1;
                end
            end else if (rev_pulse_reg == 18'h0) begin
                rev_pulse_reg <= REV_LAST;
                rev_reg <= rev_reg - 15'sh1;
            end else begin
                rev_pulse_reg <= rev_pulse_reg - 18'h1;
            end
            if (move_dir && rev_pulse_reg == REV_LAST &&
                rev_reg >= $signed(`REV_OVERFLOW - 15'h1) ||
                !move_dir && rev_pulse_reg == 18'h1 && rev_reg <= -$signed(`REV_OVERFLOW)) begin
                pos_overflow <= 1'b1;
            end
        end
    end
endmodule // indexer_station_positioning

/* File: rtl/reply_formatter.v */
`include "indexer_defines.vh"
module reply_formatter #(
    parameter [119:0] VERSION_STRING = "A0.00.0 EXAMPLE"
) (
    input wire [7:0] query_cmd,
    input wire [7:0] query_data,
    input wire [31:0] position,
    output reg [127:0] reply_chars,
    output reg reply_ok
);
    wire [63:0] hex_chars;
    genvar i;

    generate
        for (i = 0; i < 8; i = i + 1) begin : g_hex
            wire [3:0] nib;
            assign nib = position[4*i+3:4*i];
            assign hex_chars[8*i+7:8*i] = (nib < 4'ha) ? {4'h3, nib} :
                {4'h4, nib - 4'h9};
        end
    endgenerate

    always @* begin
        reply_chars = {16{`CHAR_SPACE}};
        reply_ok = 1'b0;
        if (query_cmd == `QRY_CMD_READ && query_data == `QRY_DATA_CMD_POS) begin
            reply_chars = {hex_chars, {8{`CHAR_SPACE}}};
            reply_ok = 1'b1;
        end else if (query_cmd == `QRY_CMD_READ && query_data == `QRY_DATA_VERSION) begin
            // Leading space, then the fixed-width version field
            reply_chars = {`CHAR_SPACE, VERSION_STRING};
            reply_ok = 1'b1;
        end
    end
endmodule // reply_formatter

/* File: rtl/station_path_select.v */
module station_path_select (
    input wire [31:0] pos,
    input wire [31:0] target,
    input wire [31:0] total,
    input wire fixed_dir,
    input wire shortest,
    output wire dir,
    output wire at_target
);
    wire [31:0] fwd_dist;
    wire [31:0] back_dist;

    assign fwd_dist = (target >= pos) ? target - pos : target + total - pos;
    assign back_dist = total - fwd_dist;
    assign at_target = (pos == target);
    // High dir means forward
    assign dir = shortest ? (fwd_dist <= back_dist) : fixed_dir;
endmodule // station_path_select

/* File: tb/fieldbus_master.sv */
module fieldbus_master (
    input wire aclk,
    input wire [7:0] st_cmd,
    input wire [2:0] sp_cmd,
    input wire go_cmd,
    output logic [7:0] next_station_select = 8'h00,
    output logic [2:0] speed_select = 3'h0,
    output logic motion_start_input = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cyclic link refresh, one cycle late
    always @(posedge aclk) begin
        next_station_select <= st_cmd;
        speed_select <= sp_cmd;
        motion_start_input <= go_cmd;
    end
endmodule // fieldbus_master

/* File: tb/indexer_chk.sv */
module indexer_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire step_out,
    input wire busy,
    input wire in_position,
    input wire station_error,
    input wire pos_overflow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence aw_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence b_soon;
        ##[1:3] s_axi_bvalid;
    endsequence
    AST_AW_W: assert property ($rose(s_axi_awready) |-> s_axi_wready)
        else $error("write data not taken with address");
    AST_B_SOON: assert property (aw_taken |-> b_soon)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    AST_ONE_WR: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while response pending");
    AST_R_SOON: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    AST_OVF_HOLD: assert property (pos_overflow |=> pos_overflow)
        else $error("overflow flag not sticky");
    AST_DONE_ERR: assert property (!(in_position && station_error))
        else $error("completion and refusal together");
    AST_STEP_BUSY: assert property (step_out |-> ##[0:1] busy)
        else $error("step while idle");
endmodule // indexer_chk

bind indexer_station_positioning indexer_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .step_out, .busy,
    .in_position, .station_error, .pos_overflow);

/* File: tb/indexer_station_positioning_tb.sv */
module indexer_station_positioning_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, go = 0, sd;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, st = 0;
    logic [2:0] sp = 0;
    logic [31:0] s_axi_wdata = 0, rd;
    logic [1:0] rr, br;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire step_out, dir_out, busy, in_position, station_error, home_done, pos_overflow;
    wire motion_start_input;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] next_station_select;
    wire [2:0] speed_select;
    int err_total = 0, n_compared = 0, k, n = 0;
    always #2.5 aclk = ~aclk;
    fieldbus_master fm (.aclk, .st_cmd(st), .sp_cmd(sp), .go_cmd(go),
        .next_station_select, .speed_select, .motion_start_input);
    indexer_station_positioning #(.PULSES_PER_REV(4), .VERSION_STRING("777777777777777")) DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .next_station_select, .speed_select,
        .motion_start_input, .proximity_dog(1'b0), .zero_phase_pulse(1'b0), .step_out,
        .dir_out, .busy, .in_position, .station_error, .home_done, .pos_overflow);
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 0;
                br = s_axi_bresp;
                break;
            end
        end
    endtask
    task axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 0;
                rd = s_axi_rdata;
                rr = s_axi_rresp;
                break;
            end
        end
    endtask
    task rc(input string n, input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk(n, rd, e);
    endtask
    // Mode write, start pulse, wait for idle
    task run(input logic [31:0] c, input logic [7:0] s);
        axw(8'h00, c);
        st <= s;
        go <= 1;
        repeat (4) @(posedge aclk);
        go <= 0;
        k = 0;
        while (busy && k < 5000) begin
            @(posedge aclk);
            if (step_out) sd = dir_out;
            k++;
        end
        if (k >= 5000) err_total++;
    endtask
    task print_verdict;
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rc("divisions", 8'h04, 32'h4);
        rc("pitch", 8'h08, 32'h64);
        axr(8'h3c);
        chk("rd_resp", rr, 2);
        axw(8'h3c, 32'h1);
        chk("wr_resp", br, 2);
        $display("test registers done");
        axw(8'h20, 32'h0291);
        axr(8'h24);
        chk("pos_ok", rd[5], 1);
        rc("pos_hex", 8'h2c, 32'h30303030);
        axw(8'h20, 32'h0270);
        axr(8'h24);
        chk("ver_ok", rd[5], 1);
        rc("version", 8'h38, 32'h37373737);
        rc("ver_head", 8'h2c, 32'h20373737);
        axw(8'h20, 32'h0290);
        axr(8'h24);
        chk("bad_query", rd[5], 0);
        $display("test query done");
        axw(8'h08, 32'h4);
        axw(8'h40, 32'h1);
        axw(8'h44, 32'hffff);
        sp <= 1;
        run(32'h6, 8'h0);
        chk("no_home", station_error, 1);
        run(32'h8, 8'h2);
        chk("done", in_position, 1);
        rc("pos", 8'h28, 32'h8);
        run(32'h8, 8'h1);
        chk("dir", sd, 1);
        rc("pos", 8'h28, 32'h4);
        run(32'h1, 8'h0);
        chk("dir", sd, 0);
        run(32'h9, 8'h3);
        chk("dir", sd, 0);
        rc("pos", 8'h28, 32'hc);
        $display("test indexing done");
        run(32'h0, 8'h4);
        chk("range", station_error, 1);
        axw(8'h04, 32'hff);
        axw(8'h0c, 32'hffff);
        run(32'h0, 8'h1f);
        chk("one_link", station_error, 1);
        axw(8'h44, 32'h1);
        run(32'h18, 8'h1f);
        chk("two_link", in_position, 1);
        rc("pos", 8'h28, 32'h7c);
        run(32'h10, 8'hff);
        chk("max", station_error, 1);
        $display("test refusal done");
        axw(8'h10, 32'h20);
        run(32'h5, 8'h0);
        chk("home", home_done, 1);
        rc("home_pos", 8'h28, 32'h20);
        axw(8'h18, 32'hffff);
        axw(8'h00, 32'h3);
        go <= 1;
        k = 0;
        while (!pos_overflow && k < 40000) begin
            @(posedge aclk);
            if (step_out) n++;
            k++;
        end
        go <= 0;
        chk("overflow", pos_overflow, 1);
        chk("ovf_steps", n, 32'h8000);
        $display("test home and jog done");
        print_verdict;
    end
endmodule // indexer_station_positioning_tb
